// ===== common/fault_flag_pkg.sv
package fault_flag_pkg;

  localparam int CHANNELS = 8;
  localparam logic [7:0] BASE_ADDR = 8'h00;
  localparam logic [7:0] OFF_DIAG_EN_OFFSET = 8'h0D;
  localparam logic [7:0] OVERLOAD_CLEAR_OFFSET = 8'h0F;
  localparam logic [7:0] OVERLOAD_FLAGS_OFFSET = 8'h12;
  localparam logic [7:0] OFF_OPEN_LOAD_OFFSET = 8'h13;
  localparam logic [7:0] ON_OPEN_LOAD_OFFSET = 8'h14;
  localparam logic [7:0] SHORT_FLAGS_OFFSET = 8'h15;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] OFF_DIAG_EN_RESET = 8'h00;

  typedef struct packed {
    logic [7:0] overload;
    logic [7:0] off_open;
    logic [7:0] on_open;
    logic [7:0] short_gb;
  } fault_vec_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : fault_flag_pkg

// ===== verilog/flag_latch.sv
`timescale 1ns/1ns
`default_nettype none

// One bank of per-channel sticky flags; a set always beats a clear.
module flag_latch #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clear_in,
  output logic [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign flags_next[i] = set_in[i] | (flags_reg[i] & ~clear_in[i]);
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= WIDTH'(fault_flag_pkg::FLAGS_RESET);
    end else if (clk_en) begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule : flag_latch

`default_nettype wire

// ===== verilog/channel_fault_flag_bank.sv
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Bit n of every flag register reports channel n; bit 7 is channel 7.
// - Overload flags at 0x12 read 1 after overcurrent or overtemperature.
// - Writing 1 to clear register 0x0F clears overload bit; 0 ignored.
// - Register 0x13 flags open load seen while driver off.
// - Register 0x14 flags open load seen while driver on.
// - Register 0x15 flags short to ground or battery seen in off state.
// - Base address is zero, so offsets are absolute addresses.
// - Flag registers reset to zero only on power-on reset.
// - Off-state diagnosis runs only for channels enabled in register 0x0D.
module channel_fault_flag_bank #(
  parameter int CHANNELS = fault_flag_pkg::CHANNELS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire fault_flag_pkg::reg_req_t req,
  input wire fault_flag_pkg::fault_vec_t detect,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic [7:0] off_diag_enable
);

  // The flags only respond to power-on reset; other reset sources stay
  // outside this block so a soft reset cannot hide a past fault.
  logic [7:0] off_en_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic [7:0] abs_addr;
  logic hit_ovl, hit_offo, hit_ono, hit_shg, hit_en, hit_clr;
  logic rd_ovl, rd_offo, rd_ono, rd_shg;
  logic [7:0] ovl_flags, offo_flags, ono_flags, shg_flags;
  logic [7:0] ovl_clear;
  logic [7:0] offo_set, shg_set;
  logic [7:0] rdata_next;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    addr_is = (a == 8'(fault_flag_pkg::BASE_ADDR + off));
  endfunction : addr_is

  assign abs_addr = req.addr;
  assign hit_ovl = addr_is(abs_addr, fault_flag_pkg::OVERLOAD_FLAGS_OFFSET);
  assign hit_offo = addr_is(abs_addr, fault_flag_pkg::OFF_OPEN_LOAD_OFFSET);
  assign hit_ono = addr_is(abs_addr, fault_flag_pkg::ON_OPEN_LOAD_OFFSET);
  assign hit_shg = addr_is(abs_addr, fault_flag_pkg::SHORT_FLAGS_OFFSET);
  assign hit_en = addr_is(abs_addr, fault_flag_pkg::OFF_DIAG_EN_OFFSET);
  assign hit_clr = addr_is(abs_addr, fault_flag_pkg::OVERLOAD_CLEAR_OFFSET);

  assign rd_ovl = req.rd & hit_ovl;
  assign rd_offo = req.rd & hit_offo;
  assign rd_ono = req.rd & hit_ono;
  assign rd_shg = req.rd & hit_shg;

  // Clearing only on written ones keeps other channels' faults intact.
  assign ovl_clear = (req.wr & hit_clr) ? req.wdata : 8'h00;

  // Off-state results from disabled channels are dropped.
  assign offo_set = detect.off_open & off_en_reg;
  assign shg_set = detect.short_gb & off_en_reg;

  flag_latch #(.WIDTH(CHANNELS)) u_ovl (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .set_in(detect.overload),
    .clear_in(ovl_clear),
    .flags(ovl_flags)
  );

  flag_latch #(.WIDTH(CHANNELS)) u_offo (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .set_in(offo_set),
    .clear_in({8{rd_offo}}),
    .flags(offo_flags)
  );

  flag_latch #(.WIDTH(CHANNELS)) u_ono (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .set_in(detect.on_open),
    .clear_in({8{rd_ono}}),
    .flags(ono_flags)
  );

  flag_latch #(.WIDTH(CHANNELS)) u_shg (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .set_in(shg_set),
    .clear_in({8{rd_shg}}),
    .flags(shg_flags)
  );

  // Bit n of each register is channel n, no reordering.
  assign rdata_next = hit_ovl ? ovl_flags :
                      hit_offo ? offo_flags :
                      hit_ono ? ono_flags :
                      hit_shg ? shg_flags :
                      hit_en ? off_en_reg :
                      8'h00;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      off_en_reg <= fault_flag_pkg::OFF_DIAG_EN_RESET;
    end else if (clk_en && req.wr && hit_en) begin
      off_en_reg <= req.wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= fault_flag_pkg::FLAGS_RESET;
      rvalid_reg <= 1'b0;
    end else if (clk_en) begin
      rvalid_reg <= req.rd;
      if (req.rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign rdata = rdata_reg;
  assign rvalid = rvalid_reg;
  assign off_diag_enable = off_en_reg;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_read_short;
    clk_en && rd_shg && (detect.short_gb & off_en_reg) == 8'h00;
  endsequence

  sequence s_read_on_open;
    clk_en && rd_ono && detect.on_open == 8'h00;
  endsequence

  sequence s_read_off_open;
    clk_en && rd_offo && (detect.off_open & off_en_reg) == 8'h00;
  endsequence

  // A flag set by a one-cycle pulse must survive the quiet cycle after it.
  sequence s_on_pulse_quiet;
    (clk_en && detect.on_open[7]) ##1 (clk_en && !rd_ono);
  endsequence

  read_returns_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (clk_en && req.rd && hit_ovl) |=> (rdata == $past(ovl_flags) && rvalid))
    else $error("read data mismatch");

  ovl_sets_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (clk_en && detect.overload[0]) |=> ovl_flags[0])
    else $error("overload flag not set");

  flag_write_ignored_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (clk_en && req.wr && req.addr == fault_flag_pkg::OVERLOAD_FLAGS_OFFSET
     && detect.overload == 8'h00) |=> ovl_flags == $past(ovl_flags))
    else $error("overload flags changed by a write");

  ovl_clear_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (clk_en && req.wr && hit_clr && req.wdata[3] && !detect.overload[3])
    |=> !ovl_flags[3])
    else $error("overload clear failed");

  ovl_zero_write_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (clk_en && ovl_flags[5] && !(req.wr && hit_clr && req.wdata[5]))
    |=> ovl_flags[5])
    else $error("overload flag lost");

  clear_reads_zero_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (clk_en && req.rd && req.addr == fault_flag_pkg::OVERLOAD_CLEAR_OFFSET)
    |=> rdata == 8'h00)
    else $error("clear register read back nonzero");

  offo_sets_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (clk_en && detect.off_open[2] && off_en_reg[2]) |=> offo_flags[2])
    else $error("off open load not set");

  ono_sets_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (clk_en && detect.on_open[7]) |=> ono_flags[7])
    else $error("on open load not set");

  short_sets_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (clk_en && detect.short_gb[6] && off_en_reg[6]) |=> shg_flags[6])
    else $error("short flag not set");

  short_read_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (clk_en && rd_shg) |=> rdata == $past(shg_flags))
    else $error("short flags read back wrong");

  unmapped_zero_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (clk_en && req.rd && req.addr > fault_flag_pkg::SHORT_FLAGS_OFFSET)
    |=> rdata == 8'h00)
    else $error("unmapped address read nonzero");

  reset_clear_a: assert property (
    @(posedge clock)
    $rose(rst_n) |->
      {ovl_flags, offo_flags, ono_flags, shg_flags} == 32'h00000000)
    else $error("flags not cleared by reset");

  short_read_clr_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_read_short |=> (shg_flags == 8'h00))
    else $error("short flags not cleared by read");

  offo_read_clr_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_read_off_open |=> (offo_flags == 8'h00))
    else $error("off open load flags not cleared by read");

  ono_read_clr_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_read_on_open |=> (ono_flags == 8'h00))
    else $error("on open load flags not cleared by read");

  offo_hold_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (clk_en && offo_flags[1] && !rd_offo) |=> offo_flags[1])
    else $error("off open load flag lost");

  on_open_hold_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_on_pulse_quiet |=> ono_flags[7])
    else $error("on open load flag not held");

  off_gate_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (clk_en && !off_en_reg[4] && !offo_flags[4]) |=> !offo_flags[4])
    else $error("disabled channel flagged");

  short_gate_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (clk_en && !off_en_reg[0] && !shg_flags[0]) |=> !shg_flags[0])
    else $error("disabled channel short flagged");

  en_write_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (clk_en && req.wr && req.addr == fault_flag_pkg::OFF_DIAG_EN_OFFSET)
    |=> off_diag_enable == $past(req.wdata))
    else $error("enable register write lost");

  read_valid_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (clk_en && req.rd) |=> rvalid)
    else $error("read not answered");

  idle_valid_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    (clk_en && !req.rd) |=> !rvalid)
    else $error("answer without a read");

  frozen_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !clk_en |=> $stable(shg_flags) && $stable(rdata))
    else $error("state changed while frozen");

endmodule : channel_fault_flag_bank

`default_nettype wire

// ===== verif/host_model.sv
`timescale 1ns/1ns
`default_nettype none

// Host on the register port. Released address and data lines show the inverse of the last
// value, so a design that samples them a cycle late cannot pass by luck.
module host_model (
  input wire logic clock,
  output var fault_flag_pkg::reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial req = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic v);
    @(posedge clock);
    req <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clock);
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    #1 q = rdata;
    v = rvalid;
  endtask : xfer
endmodule : host_model

`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic clock, rst_n, clk_en, rvalid, v;
  logic [7:0] rdata, off_diag_enable, q, e, m;
  fault_flag_pkg::reg_req_t req;
  fault_flag_pkg::fault_vec_t detect, d;
  int error_cnt, cmp_count, cyc;
  channel_fault_flag_bank uut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .req(req), .detect(detect), .rdata(rdata), .rvalid(rvalid),
    .off_diag_enable(off_diag_enable));
  host_model host (.clock(clock), .req(req), .rdata(rdata), .rvalid(rvalid));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.xfer(1'b0, a, 8'h00, q, v);
    check({7'h00, v}, 8'h01);
    check(q, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] dd);
    host.xfer(1'b1, a, dd, q, v);
  endtask : wr
  // Off-state flags only latch on channels whose diagnosis is enabled.
  function automatic logic [7:0] flag_exp(input logic [7:0] a,
      input fault_flag_pkg::fault_vec_t f, input logic [7:0] en);
    case (a)
      fault_flag_pkg::OVERLOAD_FLAGS_OFFSET: return f.overload;
      fault_flag_pkg::OFF_OPEN_LOAD_OFFSET: return f.off_open & en;
      fault_flag_pkg::ON_OPEN_LOAD_OFFSET: return f.on_open;
      fault_flag_pkg::SHORT_FLAGS_OFFSET: return f.short_gb & en;
      default: return 8'h00;
    endcase
  endfunction : flag_exp
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    cyc++;
    if (cyc > 3000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    detect = '0;
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    void'($urandom(12430));
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    check(off_diag_enable, 8'h00);
    for (int i = 0; i < 4; i++) rd(8'(i) + 8'h12, 8'h00);
    for (int t = 0; t < 10; t++) begin
      d = (t == 0) ? {4{8'h80}} : $urandom;
      e = (t == 0) ? 8'hFF : 8'($urandom);
      m = 8'($urandom);
      wr(fault_flag_pkg::OFF_DIAG_EN_OFFSET, e);
      check(off_diag_enable, e);
      @(posedge clock) detect <= d;
      @(posedge clock) detect <= '0;
      for (int i = 0; i < 4; i++)
        rd(8'(i) + 8'h12, flag_exp(8'(i) + 8'h12, d, e));
      for (int i = 1; i < 4; i++) rd(8'(i) + 8'h12, 8'h00);
      wr(fault_flag_pkg::OVERLOAD_FLAGS_OFFSET, 8'hFF);
      wr(fault_flag_pkg::OVERLOAD_CLEAR_OFFSET, m);
      rd(8'h12, d.overload & ~m);
      wr(fault_flag_pkg::OVERLOAD_CLEAR_OFFSET, 8'hFF);
      rd(8'h12, 8'h00);
      rd(8'h0F, 8'h00);
      rd(8'h30 + 8'(t), 8'h00);
      $display("test %0d done", t);
    end
    // A detector still high while its flag is cleared must keep the flag.
    detect <= {4{8'h01}};
    wr(fault_flag_pkg::OVERLOAD_CLEAR_OFFSET, 8'h01);
    rd(fault_flag_pkg::ON_OPEN_LOAD_OFFSET, 8'h01);
    detect <= '0;
    rd(fault_flag_pkg::OVERLOAD_FLAGS_OFFSET, 8'h01);
    rd(fault_flag_pkg::ON_OPEN_LOAD_OFFSET, 8'h01);
    rd(fault_flag_pkg::ON_OPEN_LOAD_OFFSET, 8'h00);
    $display("corner test done");
    @(posedge clock) detect <= {4{8'hFF}};
    @(posedge clock) detect <= '0;
    clk_en <= 1'b0;
    wr(fault_flag_pkg::OFF_DIAG_EN_OFFSET, ~e);
    check(off_diag_enable, e);
    host.xfer(1'b0, fault_flag_pkg::OFF_OPEN_LOAD_OFFSET, 8'h00, q, v);
    check({7'h00, v}, 8'h00);
    @(posedge clock) clk_en <= 1'b1;
    rd(fault_flag_pkg::OFF_OPEN_LOAD_OFFSET, e);
    rd(fault_flag_pkg::OVERLOAD_FLAGS_OFFSET, 8'hFF);
    rst_n <= 1'b0;
    @(posedge clock) rst_n <= 1'b1;
    check(off_diag_enable, 8'h00);
    for (int i = 0; i < 4; i++) rd(8'(i) + 8'h12, 8'h00);
    $display("reset test done");
    final_report();
  end
endmodule : tb

`default_nettype wire
